// ---- design/ts_sensor_regs.sv ----
// Register file, conversion timebase and threshold flag logic of the temperature sensor.
// Assumes conv_value_i is the converter output on clock_i; serial pins are asynchronous.
//
// Overview of operation
// - Pointer register is 8 bits; only bits 1:0 store, the rest read zero.
// - Pointer 0 selects result, 1 settings, 2 low threshold, 3 high threshold.
// - Result is read-only; settings and both thresholds are read and write.
// - Operating settings register is sixteen bits of mode fields.
// - Sixteen-bit transfers carry the most significant byte first.
// - Settings bits 3:0 and 14:13 are read-only and keep their defaults.
// - With sense zero, flag reads 1 and drops to 0 after enough high readings.
// - Active flag holds until enough readings fall to the low threshold.
// - Flag sense bit sets which flag level means over-temperature.
// - In comparator behaviour the flag equals the warning pin level.
// - Sample rate field gives 0.25, 1, 4 or 8 conversions per second.
// - After reset the sample rate is four conversions per second.
// - Result register changes only when a conversion completes.
// - Alert mode select 0 means comparator, 1 means interrupt behaviour.
// - Sense zero makes the warning pin active low, one active high.
// - Fault count codes 00, 01, 10, 11 need 1, 2, 4, 6 readings.
`timescale 1ns/1ps
module ts_sensor_regs
    import ts_pkg::*;
#(
    parameter int CONV_CYC_0 = CONV_MS_0 * CYC_PER_MS,
    parameter int CONV_CYC_1 = CONV_MS_1 * CYC_PER_MS,
    parameter int CONV_CYC_2 = CONV_MS_2 * CYC_PER_MS,
    parameter int CONV_CYC_3 = CONV_MS_3 * CYC_PER_MS
)
(
    input  wire logic           clock_i,
    input  wire logic           sys_rst_i,
    input  wire logic           scl_i,
    input  wire logic           sda_i,
    output logic                sda_o,
    output logic                sda_oe_o,
    input  wire logic [15:0]    conv_value_i,
    output logic                alert_o,
    output logic                alert_oe_o
);
    import ts_pkg::*;

    ts_wr_t        wr;
    logic          rd_start;
    logic [1:0]    pointer_reg;
    logic [7:0]    msb_hold_reg;
    logic [15:0]   temperature_result_reg;
    logic [15:0]   settings_reg;
    logic [15:0]   low_threshold_reg;
    logic [15:0]   high_threshold_reg;
    logic [15:0]   rd_word_reg;
    logic [15:0]   rd_word_next;
    logic [15:0]   wr_word;
    logic [31:0]   conv_cnt_reg;
    logic [31:0]   conv_limit;
    logic          conv_done_reg;
    logic          over_reg;
    logic [2:0]    fault_cnt_reg;
    logic [2:0]    fault_need;
    logic          qualify;
    logic          flip;
    logic          pending_reg;
    logic          threshold_flag;
    logic          pin_active;
    logic          pin_level;
    logic          mode_intr;
    logic          flag_sense;

    ts_serial_slave u_slave (
        .clock_i    (clock_i),
        .sys_rst_i  (sys_rst_i),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .sda_o      (sda_o),
        .sda_oe_o   (sda_oe_o),
        .rd_word_i  (rd_word_reg),
        .wr_o       (wr),
        .rd_start_o (rd_start)
    );

    assign wr_word    = {msb_hold_reg, wr.data};
    assign mode_intr  = settings_reg[CFG_MODE];
    assign flag_sense = settings_reg[CFG_SENSE];

    // Pointer and write path
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pointer_reg  <= PTR_TEMP;
            msb_hold_reg <= 8'h00;
        end else if (wr.valid) begin
            if (wr.idx == IDX_PTR) begin
                pointer_reg <= wr.data[1:0];
            end else if (wr.idx == IDX_MSB) begin
                msb_hold_reg <= wr.data;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            settings_reg       <= CFG_RST;
            low_threshold_reg  <= LOW_RST;
            high_threshold_reg <= HIGH_RST;
        end else if (wr.valid && wr.idx == IDX_LSB) begin
            // Data goes to the settings or threshold register the pointer last named; writes to the result are dropped
            if (pointer_reg == PTR_CFG) begin
                settings_reg <= (wr_word & CFG_WR_MASK) | (CFG_RST & ~CFG_WR_MASK);
            end else if (pointer_reg == PTR_LOW) begin
                low_threshold_reg <= wr_word;
            end else if (pointer_reg == PTR_HIGH) begin
                high_threshold_reg <= wr_word;
            end
        end
    end

    // Read word is captured when a read begins so both bytes belong together
    always_comb begin
        rd_word_next = {6'h00, 8'h00, pointer_reg};
        if (pointer_reg == PTR_TEMP) begin
            rd_word_next = temperature_result_reg;
        end else if (pointer_reg == PTR_CFG) begin
            rd_word_next = settings_reg;
            rd_word_next[CFG_FLAG] = threshold_flag;
        end else if (pointer_reg == PTR_LOW) begin
            rd_word_next = low_threshold_reg;
        end else begin
            rd_word_next = high_threshold_reg;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rd_word_reg <= 16'h0000;
        end else if (rd_start) begin
            rd_word_reg <= rd_word_next;
        end
    end

    // Conversion timebase; sleep stops new conversions
    always_comb begin
        case (settings_reg[CFG_RATE_HI:CFG_RATE_LO])
            2'h0:    conv_limit = CONV_CYC_0;
            2'h1:    conv_limit = CONV_CYC_1;
            2'h2:    conv_limit = CONV_CYC_2;
            default: conv_limit = CONV_CYC_3;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            conv_cnt_reg  <= 32'h0000_0000;
            conv_done_reg <= 1'b0;
        end else begin
            conv_done_reg <= 1'b0;
            if (conv_cnt_reg >= conv_limit - 32'h1) begin
                conv_cnt_reg  <= 32'h0000_0000;
                conv_done_reg <= ~settings_reg[CFG_SLEEP];
            end else begin
                conv_cnt_reg <= conv_cnt_reg + 32'h1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            temperature_result_reg <= TEMP_RST;
        end else if (conv_done_reg) begin
            temperature_result_reg <= conv_value_i;
        end
    end

    // Threshold tracking with hysteresis and consecutive-fault filter
    always_comb begin
        case (settings_reg[CFG_FCS_HI:CFG_FCS_LO])
            2'h0:    fault_need = 3'h1;
            2'h1:    fault_need = 3'h2;
            2'h2:    fault_need = 3'h4;
            default: fault_need = 3'h6;
        endcase
    end

    assign qualify = over_reg ? ($signed(conv_value_i) <= $signed(low_threshold_reg))
                              : ($signed(conv_value_i) >= $signed(high_threshold_reg));
    assign flip    = conv_done_reg && qualify && (fault_cnt_reg + 3'h1 >= fault_need);

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            over_reg      <= 1'b0;
            fault_cnt_reg <= 3'h0;
        end else if (conv_done_reg) begin
            if (flip) begin
                over_reg      <= ~over_reg;
                fault_cnt_reg <= 3'h0;
            end else if (qualify) begin
                fault_cnt_reg <= fault_cnt_reg + 3'h1;
            end else begin
                fault_cnt_reg <= 3'h0;
            end
        end
    end

    // Interrupt behaviour: any read or entering sleep clears, a new crossing wins
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pending_reg <= 1'b0;
        end else if (flip && mode_intr) begin
            pending_reg <= 1'b1;
        end else if (rd_start || !mode_intr || settings_reg[CFG_SLEEP]) begin
            pending_reg <= 1'b0;
        end
    end

    assign threshold_flag = flag_sense ? over_reg : ~over_reg;
    assign pin_active     = mode_intr ? pending_reg : over_reg;
    assign pin_level      = flag_sense ? pin_active : ~pin_active;

    // Open-drain pin: enable pulls low, so enable is the inverse of the level
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            alert_o    <= 1'b1;
            alert_oe_o <= 1'b0;
        end else begin
            alert_o    <= pin_level;
            alert_oe_o <= ~pin_level;
        end
    end
endmodule : ts_sensor_regs

// ---- design/ts_pkg.sv ----
// Shared constants and carrier types for the temperature sensor register and alert logic.
// Assumes one system clock at CLK_HZ; every count here derives from it.
package ts_pkg;
    localparam int          CLK_HZ        = 250_000_000;
    localparam int          CYC_PER_MS    = CLK_HZ / 1000;

    // Register pointer values
    localparam logic [1:0]  PTR_TEMP      = 2'h0;
    localparam logic [1:0]  PTR_CFG       = 2'h1;
    localparam logic [1:0]  PTR_LOW       = 2'h2;
    localparam logic [1:0]  PTR_HIGH      = 2'h3;
    localparam int          PTR_WIDTH     = 8;

    // Operating settings field positions
    localparam int          CFG_SS        = 15;
    localparam int          CFG_FCS_HI    = 12;
    localparam int          CFG_FCS_LO    = 11;
    localparam int          CFG_SENSE     = 10;
    localparam int          CFG_MODE      = 9;
    localparam int          CFG_SLEEP     = 8;
    localparam int          CFG_RATE_HI   = 7;
    localparam int          CFG_RATE_LO   = 6;
    localparam int          CFG_FLAG      = 5;
    localparam logic [15:0] CFG_WR_MASK   = 16'h9fd0;
    localparam logic [15:0] CFG_RST       = 16'h40a0;

    // Threshold and result reset values
    localparam logic [15:0] LOW_RST       = 16'h4b00;
    localparam logic [15:0] HIGH_RST      = 16'h5000;
    localparam logic [15:0] TEMP_RST      = 16'h0000;

    // Conversion periods per sample rate code
    localparam int          CONV_MS_0     = 4000;
    localparam int          CONV_MS_1     = 1000;
    localparam int          CONV_MS_2     = 250;
    localparam int          CONV_MS_3     = 125;

    // Serial slave address, arbitrary default
    localparam logic [6:0]  SLAVE_ADDR    = 7'h48;

    // Byte index of a written serial byte
    localparam logic [1:0]  IDX_PTR       = 2'h0;
    localparam logic [1:0]  IDX_MSB       = 2'h1;
    localparam logic [1:0]  IDX_LSB       = 2'h2;

    typedef struct packed {
        logic       valid;
        logic [1:0] idx;
        logic [7:0] data;
    } ts_wr_t;
endpackage : ts_pkg

// ---- design/ts_serial_slave.sv ----
// Byte-level two-wire serial slave: start/stop, address match, byte writes, 16-bit reads.
// Assumes clock line and data line are asynchronous pins oversampled by clock_i.
`timescale 1ns/1ps
module ts_serial_slave
    import ts_pkg::*;
(
    input  wire logic           clock_i,
    input  wire logic           sys_rst_i,
    input  wire logic           scl_i,
    input  wire logic           sda_i,
    output logic                sda_o,
    output logic                sda_oe_o,
    input  wire logic [15:0]    rd_word_i,
    output ts_pkg::ts_wr_t      wr_o,
    output logic                rd_start_o
);
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK_ADDR, S_WRITE, S_ACK_WR, S_READ, S_ACK_RD} ts_state_t;

    ts_state_t   state_reg;
    logic [1:0]  scl_sync_reg;
    logic [1:0]  sda_sync_reg;
    logic        scl_d_reg;
    logic        sda_d_reg;
    logic [7:0]  shift_reg;
    logic [3:0]  cnt_reg;
    logic        rw_reg;
    logic        rd_lsb_reg;
    logic [1:0]  idx_reg;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            scl_d_reg    <= scl_sync_reg[1];
            sda_d_reg    <= sda_sync_reg[1];
        end
    end

    assign scl_rise  = scl_sync_reg[1] & ~scl_d_reg;
    assign scl_fall  = ~scl_sync_reg[1] & scl_d_reg;
    assign start_det = scl_sync_reg[1] & scl_d_reg & sda_d_reg & ~sda_sync_reg[1];
    assign stop_det  = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg & sda_sync_reg[1];

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_reg  <= S_IDLE;
            shift_reg  <= 8'h00;
            cnt_reg    <= 4'h0;
            rw_reg     <= 1'b0;
            rd_lsb_reg <= 1'b0;
            idx_reg    <= IDX_PTR;
            sda_oe_o   <= 1'b0;
            sda_o      <= 1'b0;
            wr_o       <= '0;
            rd_start_o <= 1'b0;
        end else begin
            wr_o.valid <= 1'b0;
            rd_start_o <= 1'b0;
            if (start_det) begin
                state_reg <= S_ADDR;
                cnt_reg   <= 4'h0;
                sda_oe_o  <= 1'b0;
            end else if (stop_det) begin
                state_reg <= S_IDLE;
                sda_oe_o  <= 1'b0;
            end else begin
                case (state_reg)
                    S_ADDR, S_WRITE: begin
                        if (scl_rise && cnt_reg < 4'h8) begin
                            shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
                            cnt_reg   <= cnt_reg + 4'h1;
                        end else if (scl_fall && cnt_reg == 4'h8) begin
                            if (state_reg == S_ADDR) begin
                                if (shift_reg[7:1] == SLAVE_ADDR) begin
                                    rw_reg     <= shift_reg[0];
                                    rd_start_o <= shift_reg[0];
                                    rd_lsb_reg <= 1'b0;
                                    idx_reg    <= IDX_PTR;
                                    sda_oe_o   <= 1'b1;
                                    state_reg  <= S_ACK_ADDR;
                                end else begin
                                    state_reg <= S_IDLE;
                                end
                            end else begin
                                // Pointer byte first, then MSB before LSB
                                wr_o.valid <= 1'b1;
                                wr_o.idx   <= idx_reg;
                                wr_o.data  <= shift_reg;
                                idx_reg    <= (idx_reg == IDX_MSB) ? IDX_LSB : IDX_MSB;
                                sda_oe_o   <= 1'b1;
                                state_reg  <= S_ACK_WR;
                            end
                        end
                    end
                    S_ACK_ADDR, S_ACK_WR: begin
                        if (scl_fall) begin
                            cnt_reg <= 4'h0;
                            if (state_reg == S_ACK_ADDR && rw_reg) begin
                                shift_reg  <= rd_word_i[15:8];
                                sda_oe_o   <= ~rd_word_i[15];
                                rd_lsb_reg <= 1'b1;
                                state_reg  <= S_READ;
                            end else begin
                                sda_oe_o  <= 1'b0;
                                state_reg <= S_WRITE;
                            end
                        end
                    end
                    S_READ: begin
                        if (scl_fall) begin
                            if (cnt_reg == 4'h7) begin
                                sda_oe_o  <= 1'b0;
                                state_reg <= S_ACK_RD;
                            end else begin
                                shift_reg <= {shift_reg[6:0], 1'b0};
                                sda_oe_o  <= ~shift_reg[6];
                                cnt_reg   <= cnt_reg + 4'h1;
                            end
                        end
                    end
                    S_ACK_RD: begin
                        // Host not-acknowledge ends the read
                        if (scl_rise && sda_sync_reg[1]) begin
                            state_reg <= S_IDLE;
                        end else if (scl_fall) begin
                            shift_reg  <= rd_lsb_reg ? rd_word_i[7:0] : rd_word_i[15:8];
                            sda_oe_o   <= rd_lsb_reg ? ~rd_word_i[7] : ~rd_word_i[15];
                            rd_lsb_reg <= ~rd_lsb_reg;
                            cnt_reg    <= 4'h0;
                            state_reg  <= S_READ;
                        end
                    end
                    default: begin
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule : ts_serial_slave

// ---- bench/ts_sensor_regs_monitor.sv ----
// Checker for the sensor register and alert block, bound to its pins.
// Assumes each host serial clock phase lasts at least eight system clocks.
`timescale 1ns/1ps
module ts_sensor_regs_monitor (
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    input wire logic        scl_i,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe_o,
    input wire logic [15:0] conv_value_i,
    input wire logic        alert_o,
    input wire logic        alert_oe_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    logic [4:0] scl_hi_reg;
    // Saturating count of an idle-high serial clock
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || !scl_i) begin
            scl_hi_reg <= 5'h00;
        end else if (scl_hi_reg != 5'h1f) begin
            scl_hi_reg <= scl_hi_reg + 5'h01;
        end
    end
    property p_open_drain; sda_o == 1'b0; endproperty
    property p_pin_pair; alert_oe_o == !alert_o; endproperty
    property p_rst_state; $fell(sys_rst_i) |-> alert_o && !sda_oe_o; endproperty
    property p_scl_hold; scl_i && $past(scl_i) && $past(scl_i, 2) && $past(scl_i, 3) |-> $stable(sda_oe_o); endproperty
    property p_drive_late; $rose(sda_oe_o) |-> !$past(scl_i) && !$past(scl_i, 2); endproperty
    property p_drive_hold; $rose(sda_oe_o) |-> sda_oe_o [*6]; endproperty
    property p_alert_settle; $changed(alert_o) |=> $stable(alert_o) [*2]; endproperty
    property p_idle_free; scl_hi_reg == 5'h1f |-> !sda_oe_o; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
    a_pin_pair: assert property (p_pin_pair) else $error("alert enable not inverse of level");
    a_rst_state: assert property (p_rst_state) else $error("bad state after reset");
    a_scl_hold: assert property (p_scl_hold) else $error("data moved while clock high");
    a_drive_late: assert property (p_drive_late) else $error("drive began too soon after clock fall");
    a_drive_hold: assert property (p_drive_hold) else $error("driven bit too short");
    a_alert_settle: assert property (p_alert_settle) else $error("alert pin glitched");
    a_idle_free: assert property (p_idle_free) else $error("data driven on idle bus");
    c_ack: cover property ($rose(sda_oe_o));
    c_alert_on: cover property ($fell(alert_o));
    c_alert_off: cover property ($rose(alert_o));
endmodule : ts_sensor_regs_monitor

bind ts_sensor_regs ts_sensor_regs_monitor u_mon (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .conv_value_i(conv_value_i), .alert_o(alert_o),
    .alert_oe_o(alert_oe_o));

// ---- bench/ts_host_model.sv ----
// Two-wire host model: makes the serial clock, pulls the data line, moves register words.
// Assumes the bench resolves the data wire with a pull-up from all pull-down enables.
`timescale 1ns/1ps
module ts_host_model
    import ts_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    int         half_cyc = 8;
    logic [7:0] rx_b;
    logic       ack_b;
    initial begin
        scl_o    = 1'b1;
        sda_oe_o = 1'b0;
    end
    // Clock moves first, data two clocks later, so data never changes at a clock edge
    task automatic step(input logic c, input logic oe);
        scl_o <= c;
        repeat (2) @(posedge clock_i);
        sda_oe_o <= oe;
        repeat (half_cyc - 2) @(posedge clock_i);
    endtask : step
    task automatic start();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : start
    task automatic byte_io(input logic [7:0] tx, input logic ak);
        for (int i = 7; i >= 0; i--) begin
            step(1'b0, ~tx[i]);
            step(1'b1, ~tx[i]);
            rx_b[i] = sda_i;
        end
        step(1'b0, ~ak);
        step(1'b1, ~ak);
        ack_b = sda_i;
    endtask : byte_io
    task automatic xfer(input logic [7:0] ptr, input logic rd, input logic [15:0] wd,
                        output logic [15:0] rdat, output logic nack);
        start();
        byte_io({SLAVE_ADDR, 1'b0}, 1'b1);
        nack = ack_b;
        byte_io(ptr, 1'b1);
        nack |= ack_b;
        rdat = wd;
        if (rd) begin
            start();
            byte_io({SLAVE_ADDR, 1'b1}, 1'b1);
            nack |= ack_b;
            byte_io(8'hff, 1'b0);
            rdat[15:8] = rx_b;
            byte_io(8'hff, 1'b1);
            rdat[7:0] = rx_b;
        end else begin
            byte_io(wd[15:8], 1'b1);
            nack |= ack_b;
            byte_io(wd[7:0], 1'b1);
            nack |= ack_b;
        end
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask : xfer
endmodule : ts_host_model

// ---- bench/tb_top.sv ----
// Self-checking bench for the sensor register and alert block driven by the host model.
// Assumes shortened conversion periods; every expectation derives from the values set here.
`timescale 1ns/1ps
module tb_top;
    import ts_pkg::*;
    localparam int P[4] = '{200, 100, 50, 25};
    logic        clock_i;
    logic        sys_rst_i;
    logic [15:0] conv_value;
    logic        scl, host_oe, dut_oe, dut_sda, alert_o, alert_oe;
    wire         sda_w     = ~(host_oe | dut_oe);
    wire         alert_pin = ~alert_oe;
    int          n_mismatch = 0;
    int          cmp_count  = 0;
    int          seed       = 42;

    ts_sensor_regs #(.CONV_CYC_0(P[0]), .CONV_CYC_1(P[1]), .CONV_CYC_2(P[2]), .CONV_CYC_3(P[3])) u_dut (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(dut_sda),
        .sda_oe_o(dut_oe), .conv_value_i(conv_value), .alert_o(alert_o), .alert_oe_o(alert_oe));
    ts_host_model u_host (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(host_oe));

    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Pin is looked at mid-cycle, away from the edge that launches it
    task automatic pin(input logic e);
        @(negedge clock_i);
        chk({15'h0, alert_pin}, {15'h0, e});
        @(posedge clock_i);
    endtask : pin
    task automatic acc(input logic [7:0] ptr, input logic rd, input logic [15:0] wd, input logic [15:0] m);
        logic [15:0] d;
        logic        nk;
        u_host.xfer(ptr, rd, wd, d, nk);
        chk({15'h0, nk}, 16'h0);
        chk(d & m, wd & m);
    endtask : acc
    task automatic wait_pin(input logic lvl, output int n);
        n = 0;
        do begin
            @(negedge clock_i);
            n++;
        end while (alert_pin !== lvl && n < 1000);
        @(posedge clock_i);
    endtask : wait_pin
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        logic [15:0] d;
        logic [15:0] shadow [4];
        logic [1:0]  p;
        logic        s;
        int          n;
        int          nf;
        sys_rst_i  = 1'b1;
        conv_value = 16'h0800;
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        shadow = '{16'h0800, CFG_RST, LOW_RST, HIGH_RST};
        for (int r = 0; r < 4; r++) begin
            acc(8'(r), 1'b1, shadow[r], 16'hffff);
        end
        $display("reset values done");
        // Comparator, one reading, active low: the pin flips once per conversion, so its spacing is the period
        for (int r = 4; r >= 0; r--) begin
            if (r < 4) begin
                acc(8'(PTR_CFG), 1'b0, 16'(r) << CFG_RATE_LO, 16'h0);
            end
            conv_value <= HIGH_RST;
            wait_pin(1'b0, n);
            conv_value <= LOW_RST;
            wait_pin(1'b1, n);
            conv_value <= HIGH_RST;
            wait_pin(1'b0, n);
            chk(16'(n), 16'(P[r % 4 == r ? r : 2]));
        end
        $display("conversion rates done");
        shadow[1] = CFG_RST & ~CFG_WR_MASK;
        conv_value <= 16'h0800;
        for (int i = 0; i < 12; i++) begin
            u_host.half_cyc = (i % 2) ? 12 : 8;
            p = 2'($random(seed));
            d = 16'($random(seed));
            if (p == PTR_CFG) begin
                d = d & 16'h7eef;
            end
            acc({6'($random(seed)), p}, 1'b0, d, 16'h0);
            if (p != PTR_TEMP) begin
                shadow[p] = (p == PTR_CFG) ? (d & CFG_WR_MASK) | (CFG_RST & ~CFG_WR_MASK) : d;
            end
            p = 2'($random(seed));
            acc(8'(p), 1'b1, shadow[p], (p == PTR_CFG) ? 16'hffdf : 16'hffff);
        end
        u_host.half_cyc = 8;
        $display("random access done");
        acc(8'(PTR_LOW), 1'b0, 16'hf000, 16'h0);
        acc(8'(PTR_HIGH), 1'b0, 16'h0100, 16'h0);
        for (int fc = 0; fc < 4; fc++) begin
            s  = fc[0];
            nf = (fc == 0) ? 1 : fc * 2;
            conv_value <= 16'hf000;
            acc(8'(PTR_CFG), 1'b0, (16'(fc) << CFG_FCS_LO) | (16'(s) << CFG_SENSE) | 16'h00c0, 16'h0);
            repeat (7 * P[3] + 4) @(posedge clock_i);
            pin(!s);
            conv_value <= 16'h0100;
            if (nf > 1) begin
                repeat ((nf - 1) * P[3] - 4) @(posedge clock_i);
            end
            pin(!s);
            repeat (2 * P[3] + 8) @(posedge clock_i);
            pin(s);
            for (int k = 0; k < 2 && nf > 1; k++) begin
                conv_value <= 16'hf000;
                repeat ((nf - 1) * P[3]) @(posedge clock_i);
                conv_value <= 16'h0000;
                repeat (P[3]) @(posedge clock_i);
            end
            pin(s);
            acc(8'(PTR_CFG), 1'b1, 16'(s) << CFG_FLAG, 16'h0020);
        end
        $display("threshold flag done");
        conv_value <= 16'hf000;
        acc(8'(PTR_CFG), 1'b0, (16'h1 << CFG_MODE) | 16'h00c0, 16'h0);
        conv_value <= 16'h0100;
        repeat (P[3] + 4) @(posedge clock_i);
        pin(1'b0);
        acc(8'(PTR_TEMP), 1'b1, 16'h0100, 16'hffff);
        pin(1'b1);
        repeat (4 * P[3]) @(posedge clock_i);
        pin(1'b1);
        conv_value <= 16'hf000;
        repeat (P[3] + 4) @(posedge clock_i);
        pin(1'b0);
        // Sleep clears a pending warning and freezes the result
        acc(8'(PTR_CFG), 1'b0, (16'h1 << CFG_MODE) | (16'h1 << CFG_SLEEP) | 16'h00c0, 16'h0);
        pin(1'b1);
        conv_value <= 16'h0100;
        repeat (4 * P[3]) @(posedge clock_i);
        acc(8'(PTR_TEMP), 1'b1, 16'hf000, 16'hffff);
        $display("interrupt mode done");
        conclude();
    end

    initial begin
        repeat (90000) @(posedge clock_i);
        n_mismatch++;
        $display("watchdog expired at %0t", $time);
        conclude();
    end
endmodule : tb_top
